// ### rtl/ddcm_dev.sv
// mixer and oscillator end of a downconverter channel
`timescale 1ns/1ps
`default_nettype none
module ddcm_dev #(
  parameter int DATA_W = ddcm_pkg::DATA_W
) (
  // control port and syncs from the controller
  ddcm_if.dev                                        bus,
  // receive input ports, same clock domain
  input  wire logic [ddcm_pkg::PORTS-1:0][DATA_W-1:0] rx_port,
  // baseband streams, index 0 is a, index 1 is b
  output wire logic [1:0][DATA_W-1:0]                 out_i,
  output wire logic [1:0][DATA_W-1:0]                 out_q,
  output wire logic [1:0]                             out_valid
);
  localparam int TW = ddcm_pkg::TRIG_W;
  localparam int PW = DATA_W + TW + 1;
  localparam logic signed [PW-1:0] SAT_HI =
    {{(PW-DATA_W+1){1'b0}}, {(DATA_W-1){1'b1}}};
  localparam logic signed [PW-1:0] SAT_LO = ~SAT_HI;

  logic        clk;
  logic        rst;
  logic [15:0] freq_lo_reg [2];
  logic [15:0] freq_hi_reg [2];
  logic [15:0] phase_reg [2];
  logic [15:0] mode_reg;
  logic [15:0] route_reg;
  logic [15:0] ssel_reg;
  logic [2:0]  div_reg;
  logic [2:0]  ratio_m1;
  logic        adv;
  logic        dual;
  logic        zero_q;
  logic        boost;
  logic        ld_freq;
  logic        ld_phase;
  logic        zero_ph;
  logic        dith_rst;
  wire logic [1:0][15:0] pm;

  assign clk = bus.clk;
  assign rst = bus.rst;

  // saturating scale back to sample width, boost drops one shift
  function automatic logic [DATA_W-1:0] scale_sat(
    input logic signed [PW-1:0] v, input logic up);
    logic signed [PW-1:0] s;
    s = up ? (v >>> (TW - 2)) : (v >>> (TW - 1));
    if (s > SAT_HI) return SAT_HI[DATA_W-1:0];
    if (s < SAT_LO) return SAT_LO[DATA_W-1:0];
    return s[DATA_W-1:0];
  endfunction

  // control-port words; frequency halves only land in staging
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int k = 0; k < 2; k++) begin
        freq_lo_reg[k] <= 16'h0;
        freq_hi_reg[k] <= 16'h0;
        phase_reg[k]   <= 16'h0;
      end
      mode_reg  <= ddcm_pkg::MODE_RST;
      route_reg <= ddcm_pkg::ROUTE_RST;
      ssel_reg  <= ddcm_pkg::SSEL_RST;
    end else if (bus.cp_wr) begin
      case (bus.cp_addr)
        ddcm_pkg::CP_FREQ_A_LO: freq_lo_reg[0] <= bus.cp_data;
        ddcm_pkg::CP_FREQ_A_HI: freq_hi_reg[0] <= bus.cp_data;
        ddcm_pkg::CP_FREQ_B_LO: freq_lo_reg[1] <= bus.cp_data;
        ddcm_pkg::CP_FREQ_B_HI: freq_hi_reg[1] <= bus.cp_data;
        ddcm_pkg::CP_PHASE_A:   phase_reg[0]   <= bus.cp_data;
        ddcm_pkg::CP_PHASE_B:   phase_reg[1]   <= bus.cp_data;
        ddcm_pkg::CP_MODE:      mode_reg       <= bus.cp_data;
        ddcm_pkg::CP_ROUTE:     route_reg      <= bus.cp_data;
        ddcm_pkg::CP_SSEL:      ssel_reg       <= bus.cp_data;
        default: ;
      endcase
    end
  end

  // mode decode
  assign dual   = mode_reg[ddcm_pkg::MODE_DUAL];
  assign zero_q = mode_reg[ddcm_pkg::MODE_ZERO_Q];
  assign boost  = mode_reg[ddcm_pkg::MODE_BOOST];

  // one sync set for the block, picked once and fed to both channels
  assign zero_ph  = bus.sync[ssel_reg[ddcm_pkg::SSEL_NCO +: 3]];
  assign dith_rst = bus.sync[ssel_reg[ddcm_pkg::SSEL_DITH +: 3]];
  assign ld_freq  = bus.sync[ssel_reg[ddcm_pkg::SSEL_FREQ +: 3]];
  assign ld_phase = bus.sync[ssel_reg[ddcm_pkg::SSEL_PHASE +: 3]];

  // rate 0..3 divides the clock by 1,2,4,8
  assign ratio_m1 =
    3'((4'h1 << mode_reg[ddcm_pkg::MODE_RATE +: 2]) - 4'h1);
  assign adv = (div_reg == ratio_m1);

  // sample strobe divider; a shrunk ratio catches up by wrapping
  always_ff @(posedge clk or posedge rst) begin
    if (rst) div_reg <= 3'h0;
    else if (adv) div_reg <= 3'h0;
    else div_reg <= div_reg + 3'h1;
  end

  // per-stream route, oscillator and mixer
  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    logic                     ch_on;
    logic [3:0]               sel;
    logic [TW-1:0]            sin_w;
    logic [TW-1:0]            cos_w;
    logic [DATA_W-1:0]        si_reg;
    logic [DATA_W-1:0]        sq_reg;
    logic                     s1_reg;
    logic signed [PW-1:0]     mi;
    logic signed [PW-1:0]     mq;
    logic [DATA_W-1:0]        oi_reg;
    logic [DATA_W-1:0]        oq_reg;
    logic                     ov_reg;

    // b stream only runs in dual mode
    assign ch_on = (ch == 0) || dual;
    assign sel   = route_reg[ch*4 +: 4];

    ddcm_nco u_nco (
      .clk         (clk),
      .rst         (rst),
      .adv         (adv & ch_on),
      .freq_stage  ({freq_hi_reg[ch], freq_lo_reg[ch]}),
      .phase_stage (phase_reg[ch]),
      .ld_freq     (ld_freq),
      .ld_phase    (ld_phase),
      .zero_ph     (zero_ph),
      .dith_rst    (dith_rst),
      .dith_en     (mode_reg[ddcm_pkg::MODE_DITH]),
      .trim        (mode_reg[ddcm_pkg::MODE_TRIM +: 2]),
      .sin_out     (sin_w),
      .cos_out     (cos_w),
      .phase_mon   (pm[ch])
    );

    // input pick lines up with the oscillator word of the same strobe
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        si_reg <= '0;
        sq_reg <= '0;
        s1_reg <= 1'b0;
      end else begin
        s1_reg <= adv & ch_on;
        if (adv & ch_on) begin
          si_reg <= rx_port[sel[ddcm_pkg::ROUTE_I +: 2]];
          sq_reg <= zero_q ? '0 :
                    rx_port[sel[ddcm_pkg::ROUTE_Q +: 2]];
        end
      end
    end

    // multiply by e^{+j theta}: positive words lift negative tones
    assign mi = PW'($signed(si_reg) * $signed(cos_w))
              - PW'($signed(sq_reg) * $signed(sin_w));
    assign mq = PW'($signed(si_reg) * $signed(sin_w))
              + PW'($signed(sq_reg) * $signed(cos_w));

    // registered stream output
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        oi_reg <= '0;
        oq_reg <= '0;
        ov_reg <= 1'b0;
      end else begin
        ov_reg <= s1_reg;
        if (s1_reg) begin
          oi_reg <= scale_sat(mi, boost);
          oq_reg <= scale_sat(mq, boost);
        end
      end
    end

    assign out_i[ch]     = oi_reg;
    assign out_q[ch]     = oq_reg;
    assign out_valid[ch] = ov_reg;
  end

  // state shown back to the controller
  assign bus.phase_a_mon = pm[0];
  assign bus.mode_mon    = mode_reg;
endmodule
`default_nettype wire

// ### rtl/ddcm_pkg.sv
// shared constants for the downconverter mixer and oscillator
package ddcm_pkg;

  // datapath widths
  localparam int DATA_W  = 18;
  localparam int TRIG_W  = 20;
  localparam int FREQ_W  = 32;
  localparam int PHASE_W = 16;
  localparam int DITH_W  = 5;
  localparam int SSEL_W  = 3;
  localparam int NSYNC   = 8;
  localparam int PORTS   = 4;
  localparam int CP_AW   = 4;
  localparam int CP_DW   = 16;

  // control-port word addresses inside the device
  localparam logic [3:0] CP_FREQ_A_LO = 4'h0;
  localparam logic [3:0] CP_FREQ_A_HI = 4'h1;
  localparam logic [3:0] CP_FREQ_B_LO = 4'h2;
  localparam logic [3:0] CP_FREQ_B_HI = 4'h3;
  localparam logic [3:0] CP_PHASE_A   = 4'h4;
  localparam logic [3:0] CP_PHASE_B   = 4'h5;
  localparam logic [3:0] CP_MODE      = 4'h6;
  localparam logic [3:0] CP_ROUTE     = 4'h7;
  localparam logic [3:0] CP_SSEL      = 4'h8;

  // mode word bit positions
  localparam int MODE_DUAL   = 0;
  localparam int MODE_REMIX  = 1;
  localparam int MODE_ZERO_Q = 2;
  localparam int MODE_BOOST  = 3;
  localparam int MODE_DITH   = 4;
  localparam int MODE_TRIM   = 5;
  localparam int MODE_RATE   = 7;

  // route word: stream a in [3:0], stream b in [7:4]; i in low pair
  localparam int ROUTE_I = 0;
  localparam int ROUTE_Q = 2;

  // sync select word field positions
  localparam int SSEL_NCO   = 0;
  localparam int SSEL_DITH  = 3;
  localparam int SSEL_FREQ  = 6;
  localparam int SSEL_PHASE = 9;

  // reset values
  localparam logic [15:0] MODE_RST  = 16'h0008;
  localparam logic [15:0] ROUTE_RST = 16'h0044;
  localparam logic [15:0] SSEL_RST  = 16'h0000;
  localparam logic [4:0]  DITH_SEED = 5'h1f;

  // apb register byte offsets of the controller
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_SYNC   = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_PHASE  = 8'h0c;
  localparam logic [7:0] REG_RATE   = 8'h10;
  localparam int CMD_ADDR = 16;
  localparam int STAT_REFUSED = 16;

  // oscillator amplitudes and first quarter wave, 8 mid-step points
  localparam logic [19:0] TRIG_FULL = 20'h7ffff;
  localparam logic [19:0] SIN_TAB [8] = '{
    20'h0c8bf, 20'h2527f, 20'h3c570, 20'h5133b,
    20'h62f1d, 20'h70e2a, 20'h7a7cf, 20'h7f620};

endpackage

// ### rtl/ddcm_if.sv
// link between the controller end and the mixer/oscillator end
`timescale 1ns/1ps
`default_nettype none
interface ddcm_if (
  input wire logic clk,
  input wire logic rst
);
  logic                        cp_wr;
  logic [ddcm_pkg::CP_AW-1:0]  cp_addr;
  logic [ddcm_pkg::CP_DW-1:0]  cp_data;
  logic [ddcm_pkg::NSYNC-1:0]  sync;
  logic [15:0]                 phase_a_mon;
  logic [15:0]                 mode_mon;

  modport dev (
    input  clk, rst, cp_wr, cp_addr, cp_data, sync,
    output phase_a_mon, mode_mon
  );
  modport ctl (
    input  clk, rst, phase_a_mon, mode_mon,
    output cp_wr, cp_addr, cp_data, sync
  );
endinterface
`default_nettype wire

// ### rtl/ddcm_nco.sv
// numerically controlled oscillator with phase offset and dither
`timescale 1ns/1ps
`default_nettype none
module ddcm_nco (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst,
  // sample strobe and staged words
  input  wire logic                        adv,
  input  wire logic [ddcm_pkg::FREQ_W-1:0] freq_stage,
  input  wire logic [ddcm_pkg::PHASE_W-1:0] phase_stage,
  // shared sync events
  input  wire logic                        ld_freq,
  input  wire logic                        ld_phase,
  input  wire logic                        zero_ph,
  input  wire logic                        dith_rst,
  // dither control
  input  wire logic                        dith_en,
  input  wire logic [1:0]                  trim,
  // sinusoid and phase monitor
  output logic [ddcm_pkg::TRIG_W-1:0]      sin_out,
  output logic [ddcm_pkg::TRIG_W-1:0]      cos_out,
  output logic [15:0]                      phase_mon
);
  logic [31:0] freq_reg;
  logic [15:0] offs_reg;
  logic [31:0] acc_reg;
  logic [4:0]  lfsr_reg;
  logic [4:0]  dith;
  logic [20:0] arg;
  logic [4:0]  idx;

  // quarter table folded to a full turn
  function automatic logic [19:0] wave(input logic [4:0] p);
    logic [19:0] m;
    m = p[3] ? ddcm_pkg::SIN_TAB[~p[2:0]] : ddcm_pkg::SIN_TAB[p[2:0]];
    return p[4] ? 20'(-m) : m;
  endfunction

  // new words wait here for their sync, never act at once
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      freq_reg <= 32'h0;
      offs_reg <= 16'h0;
    end else begin
      if (ld_freq) freq_reg <= freq_stage;
      if (ld_phase) offs_reg <= phase_stage;
    end
  end

  // two's complement wrap makes signed words tune both ways
  always_ff @(posedge clk or posedge rst) begin
    if (rst) acc_reg <= 32'h0;
    else if (zero_ph) acc_reg <= 32'h0;
    else if (adv) acc_reg <= acc_reg + freq_reg;
  end

  // 5-bit pseudonoise, restarted by its own sync
  always_ff @(posedge clk or posedge rst) begin
    if (rst) lfsr_reg <= ddcm_pkg::DITH_SEED;
    else if (dith_rst) lfsr_reg <= ddcm_pkg::DITH_SEED;
    else if (adv) lfsr_reg <= {lfsr_reg[3:0], lfsr_reg[4] ^ lfsr_reg[2]};
  end

  // dither sits below the 16 phase bits; trim kills the top two
  assign dith = dith_en ? (lfsr_reg & ~{trim, 3'b000}) : 5'h0;
  // a full 16-bit offset word spans one turn
  assign arg = 21'({acc_reg[31:16] + offs_reg, acc_reg[15:11]})
             + 21'(dith);
  assign idx = arg[20:16];
  assign phase_mon = arg[20:5];

  // table outputs, forced to zero phase on the reset sync
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sin_out <= 20'h0;
      cos_out <= ddcm_pkg::TRIG_FULL;
    end else if (zero_ph) begin
      sin_out <= 20'h0;
      cos_out <= ddcm_pkg::TRIG_FULL;
    end else if (adv) begin
      sin_out <= wave(idx);
      cos_out <= wave(5'(idx + 5'h8));
    end
  end
endmodule
`default_nettype wire

// ### rtl/ddcm_ctl.sv
// controller end: apb registers that program the mixer end
`timescale 1ns/1ps
`default_nettype none
module ddcm_ctl (
  // link to the mixer end
  ddcm_if.ctl                    bus,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output wire logic              pready,
  output wire logic              pslverr
);
  logic        clk;
  logic        rst;
  logic        access;
  logic        wr;
  logic        mapped;
  logic        cmd_bad;
  logic        refuse_set;
  logic [1:0]  rate_reg;
  logic [3:0]  cmd_addr_reg;
  logic [15:0] cmd_data_reg;
  logic        cp_wr_reg;
  logic [7:0]  sync_reg;
  logic        refused_reg;

  assign clk = bus.clk;
  assign rst = bus.rst;

  // checks a mode word against the rate and mode pairings
  function automatic logic mode_ok(input logic [15:0] d,
                                   input logic [1:0] grate);
    logic [1:0] r;
    logic       du;
    logic       rm;
    r  = d[ddcm_pkg::MODE_RATE +: 2];
    du = d[ddcm_pkg::MODE_DUAL];
    rm = d[ddcm_pkg::MODE_REMIX];
    if (r != grate) return 1'b0;
    if (rm && !(du && r == 2'h0)) return 1'b0;
    if (du && r == 2'h0 && !rm && !d[ddcm_pkg::MODE_ZERO_Q])
      return 1'b0;
    return 1'b1;
  endfunction

  // access decode; zero wait states
  assign access = psel & penable;
  assign wr     = access & pwrite;
  assign mapped = (paddr == ddcm_pkg::REG_CMD) ||
                  (paddr == ddcm_pkg::REG_SYNC) ||
                  (paddr == ddcm_pkg::REG_STATUS) ||
                  (paddr == ddcm_pkg::REG_PHASE) ||
                  (paddr == ddcm_pkg::REG_RATE);
  assign cmd_bad = (paddr == ddcm_pkg::REG_CMD) &&
    (pwdata[ddcm_pkg::CMD_ADDR +: 4] == ddcm_pkg::CP_MODE) &&
    !mode_ok(pwdata[15:0], rate_reg);
  assign refuse_set = wr & mapped & cmd_bad;
  assign pready  = 1'b1;
  assign pslverr = access & (!mapped | (pwrite & cmd_bad));

  // each accepted command becomes one control-port word, so a
  // frequency goes out as two writes, low half then high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_addr_reg <= 4'h0;
      cmd_data_reg <= 16'h0;
      cp_wr_reg    <= 1'b0;
    end else begin
      cp_wr_reg <= 1'b0;
      if (wr && paddr == ddcm_pkg::REG_CMD && !cmd_bad) begin
        cmd_addr_reg <= pwdata[ddcm_pkg::CMD_ADDR +: 4];
        cmd_data_reg <= pwdata[15:0];
        cp_wr_reg    <= 1'b1;
      end
    end
  end

  // sync pulses last one clock
  always_ff @(posedge clk or posedge rst) begin
    if (rst) sync_reg <= 8'h0;
    else if (wr && paddr == ddcm_pkg::REG_SYNC) sync_reg <= pwdata[7:0];
    else sync_reg <= 8'h0;
  end

  // global input rate select
  always_ff @(posedge clk or posedge rst) begin
    if (rst) rate_reg <= 2'h0;
    else if (wr && paddr == ddcm_pkg::REG_RATE) rate_reg <= pwdata[1:0];
  end

  // sticky refusal flag; a new refusal wins over the clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) refused_reg <= 1'b0;
    else if (refuse_set) refused_reg <= 1'b1;
    else if (wr && paddr == ddcm_pkg::REG_STATUS &&
             pwdata[ddcm_pkg::STAT_REFUSED]) refused_reg <= 1'b0;
  end

  // read data captured in the setup cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) prdata <= 32'h0;
    else if (psel && !penable && !pwrite) begin
      case (paddr)
        ddcm_pkg::REG_CMD:    prdata <= {12'h0, cmd_addr_reg, cmd_data_reg};
        ddcm_pkg::REG_STATUS: prdata <= {15'h0, refused_reg, bus.mode_mon};
        ddcm_pkg::REG_PHASE:  prdata <= {16'h0, bus.phase_a_mon};
        ddcm_pkg::REG_RATE:   prdata <= {30'h0, rate_reg};
        default:              prdata <= 32'h0;
      endcase
    end
  end

  assign bus.cp_wr   = cp_wr_reg;
  assign bus.cp_addr = cmd_addr_reg;
  assign bus.cp_data = cmd_data_reg;
  assign bus.sync    = sync_reg;
endmodule
`default_nettype wire

// ### testbench/ddcm_monitor.sv
// assertions on the link between the controller and the mixer ends
`timescale 1ns/1ps
`default_nettype none
module ddcm_monitor (
  // clock and reset
  input wire logic                       clk,
  input wire logic                       rst,
  // control words and syncs
  input wire logic                       cp_wr,
  input wire logic [ddcm_pkg::CP_AW-1:0] cp_addr,
  input wire logic [ddcm_pkg::CP_DW-1:0] cp_data,
  input wire logic [ddcm_pkg::NSYNC-1:0] sync,
  // state seen back from the mixer end
  input wire logic [15:0]                phase_a_mon,
  input wire logic [15:0]                mode_mon
);
  logic quiet_reg;
  logic dith_wr;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // a dither-enabling mode word is the only non-sync way to move the phase
  assign dith_wr = cp_wr && cp_addr == ddcm_pkg::CP_MODE
                   && cp_data[ddcm_pkg::MODE_DITH];

  // cleared for good by the first sync pulse or dither enable
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      quiet_reg <= 1'b1;
    end else if (sync != '0 || dith_wr) begin
      quiet_reg <= 1'b0;
    end
  end

  a_cpwr_single: assert property (cp_wr |=> !cp_wr)
    else $error("control word strobe held past one cycle");
  a_sync_pulse: assert property (sync != '0 |-> ##1 sync == '0)
    else $error("sync pulse held past one cycle");
  a_mode_store: assert property (
    cp_wr && cp_addr == ddcm_pkg::CP_MODE
    |=> mode_mon[8:0] == $past(cp_data[8:0]))
    else $error("mode word not stored from the control port");
  a_mode_cause: assert property (
    !$stable(mode_mon)
    |-> $past(cp_wr) && $past(cp_addr) == ddcm_pkg::CP_MODE)
    else $error("mode word changed without a mode write");
  a_mode_reset: assert property (
    $fell(rst) |-> mode_mon == ddcm_pkg::MODE_RST)
    else $error("mode word wrong after reset");
  a_remix_legal: assert property (
    mode_mon[ddcm_pkg::MODE_REMIX] |-> mode_mon[ddcm_pkg::MODE_DUAL]
    && mode_mon[ddcm_pkg::MODE_RATE +: 2] == 2'b00)
    else $error("remix set outside dual full-rate mode");
  a_dual_rate: assert property (
    mode_mon[ddcm_pkg::MODE_DUAL] && !mode_mon[ddcm_pkg::MODE_REMIX]
    && mode_mon[ddcm_pkg::MODE_RATE +: 2] == 2'b00
    |-> mode_mon[ddcm_pkg::MODE_ZERO_Q])
    else $error("dual complex input accepted at full rate");
  a_phase_quiet: assert property (quiet_reg |-> phase_a_mon == 16'h0000)
    else $error("phase moved before any sync");

  c_freq_hi: cover property (cp_wr && cp_addr == ddcm_pkg::CP_FREQ_A_HI);
  c_sync_two: cover property (sync[1] && sync[4]);
  c_dual_mode: cover property (mode_mon[ddcm_pkg::MODE_DUAL]);
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
// self-checking bench for the controller and mixer ends on one link
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct {logic [31:0] data; logic err; logic rd;} ddcm_bus_type;
  typedef struct {logic [17:0] i; logic [17:0] q; logic s;} ddcm_mix_type;

  logic             clk;
  logic             rst;
  logic             psel;
  logic             penable;
  logic             pwrite;
  logic [7:0]       paddr;
  logic [31:0]      pwdata;
  logic [31:0]      prdata;
  logic             pready;
  logic             pslverr;
  logic [3:0][17:0] rx_port;
  logic [1:0][17:0] out_i;
  logic [1:0][17:0] out_q;
  logic [1:0]       out_valid;
  ddcm_bus_type     bus_q[$];
  ddcm_mix_type     mix_q[$];
  ddcm_bus_type     bn;
  ddcm_mix_type     mn;
  int               n_fail = 0;
  int               checks_done = 0;
  integer           seed = 32'hbb0829b2;
  logic [15:0]      pa = 16'h0000;
  logic [15:0]      pb = 16'h0000;
  logic             boost = 1'b1;
  logic             zq = 1'b0;

  ddcm_if u_ddcm_if (.clk(clk), .rst(rst));
  ddcm_ctl u_ddcm_ctl (
    .bus(u_ddcm_if.ctl), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  ddcm_dev u_ddcm_dev (
    .bus(u_ddcm_if.dev), .rx_port(rx_port), .out_i(out_i), .out_q(out_q),
    .out_valid(out_valid));
  ddcm_monitor u_ddcm_monitor (
    .clk(clk), .rst(rst), .cp_wr(u_ddcm_if.cp_wr),
    .cp_addr(u_ddcm_if.cp_addr), .cp_data(u_ddcm_if.cp_data),
    .sync(u_ddcm_if.sync), .phase_a_mon(u_ddcm_if.phase_a_mon),
    .mode_mon(u_ddcm_if.mode_mon));

  // shared tally; only mismatches are printed
  task automatic tally(input logic [35:0] got, input logic [35:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_bus(input logic [31:0] got, input logic [31:0] exp);
    tally({4'h0, got}, {4'h0, exp});
  endtask
  task automatic chk_mix(input logic [35:0] got, input logic [35:0] exp);
    tally(got, exp);
  endtask
  task automatic chk_cnt(input int got, input int exp);
    tally(36'(got), 36'(exp));
  endtask

  task automatic complete_run();
    if (n_fail == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // coarse 32-point sinusoid rebuilt from the quarter wave by symmetry
  function automatic logic signed [19:0] trig(input logic [4:0] k);
    logic [19:0] m;
    m = k[3] ? ddcm_pkg::SIN_TAB[3'd7 - k[2:0]] : ddcm_pkg::SIN_TAB[k[2:0]];
    return k[4] ? -m : m;
  endfunction

  // one output part: floor shift then saturate, boost shifts one less
  function automatic logic [17:0] mac(input logic signed [17:0] x,
      input logic signed [17:0] y, input logic signed [19:0] cx,
      input logic signed [19:0] cy);
    longint p;
    p = (longint'(x) * cx + longint'(y) * cy) >>> (boost ? 18 : 19);
    if (p > 131071) p = 131071;
    if (p < -131072) p = -131072;
    return 18'(p);
  endfunction

  // one apb transfer; the expected answer is noted before setup
  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d, input logic [31:0] exp, input logic err);
    bus_q.push_back('{exp, err, !wr});
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cmd(input logic [3:0] a, input logic [15:0] d,
      input logic err);
    apb(1'b1, ddcm_pkg::REG_CMD, {12'h000, a, d}, 32'h0, err);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
      input logic err);
    apb(1'b0, a, 32'h0, exp, err);
  endtask

  // fresh samples held long enough that the next result must reflect them
  task automatic stream(input logic s);
    logic [3:0][17:0] v;
    logic [4:0]       k;
    logic [17:0]      ii;
    logic [17:0]      qq;
    for (int p = 0; p < 4; p++) v[p] = 18'($random(seed));
    @(posedge clk);
    rx_port <= v;
    repeat (16) @(posedge clk);
    k  = s ? pb[15:11] : pa[15:11];
    ii = s ? v[1] : v[2];
    qq = zq ? 18'h0 : (s ? v[0] : v[3]);
    mix_q.push_back('{mac(ii, qq, trig(k + 5'd8), -trig(k)),
                      mac(ii, qq, trig(k), trig(k + 5'd8)), s});
    while (mix_q.size() != 0) @(posedge clk);
  endtask

  // scoreboard: each access and each result takes the oldest note
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1) begin
      bn = bus_q.pop_front();
      chk_bus({31'h0, pslverr}, {31'h0, bn.err});
      if (bn.rd) chk_bus(prdata, bn.data);
    end
    if (mix_q.size() != 0 && out_valid[mix_q[0].s] === 1'b1) begin
      mn = mix_q.pop_front();
      chk_mix({out_i[mn.s], out_q[mn.s]}, {mn.i, mn.q});
    end
  end

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    complete_run();
  end

  initial begin
    logic [15:0] np;
    logic [15:0] bad [4];
    int          na;
    int          nb;
    bad = '{16'h0001, 16'h0002, 16'h0088, 16'h000b};
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    rx_port = '0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(ddcm_pkg::REG_STATUS, {16'h0, ddcm_pkg::MODE_RST}, 1'b0);
    rd(ddcm_pkg::REG_RATE, 32'h0, 1'b0);
    rd(8'h14, 32'h0, 1'b1);
    cmd(ddcm_pkg::CP_ROUTE, 16'h001e, 1'b0);
    cmd(ddcm_pkg::CP_SSEL, 16'h029c, 1'b0);
    // every quadrant, boost on and off, quadrature zeroed last
    for (int k = 0; k < 4; k++) begin
      np = 16'(k * 16'h4800);
      cmd(ddcm_pkg::CP_PHASE_A, np, 1'b0);
      rd(ddcm_pkg::REG_PHASE, {16'h0, pa}, 1'b0);
      boost = k[0];
      zq = (k == 3);
      cmd(ddcm_pkg::CP_MODE, {12'h0, boost, zq, 2'b00}, 1'b0);
      apb(1'b1, ddcm_pkg::REG_SYNC, 32'h12, 32'h0, 1'b0);
      pa = np;
      rd(ddcm_pkg::REG_PHASE, {16'h0, pa}, 1'b0);
      stream(1'b0);
    end
    // frequency halves wait for their load sync
    cmd(ddcm_pkg::CP_FREQ_A_LO, 16'h0000, 1'b0);
    cmd(ddcm_pkg::CP_FREQ_A_HI, 16'h0100, 1'b0);
    rd(ddcm_pkg::REG_PHASE, {16'h0, pa}, 1'b0);
    apb(1'b1, ddcm_pkg::REG_SYNC, 32'h04, 32'h0, 1'b0);
    // second read lands three strobes later, one word step per strobe
    rd(ddcm_pkg::REG_PHASE, {16'h0, pa}, 1'b0);
    rd(ddcm_pkg::REG_PHASE, {16'h0, pa + 16'h0300}, 1'b0);
    // a negative word walks the phase down
    cmd(ddcm_pkg::CP_FREQ_A_HI, 16'hff00, 1'b0);
    apb(1'b1, ddcm_pkg::REG_SYNC, 32'h14, 32'h0, 1'b0);
    rd(ddcm_pkg::REG_PHASE, {16'h0, pa}, 1'b0);
    rd(ddcm_pkg::REG_PHASE, {16'h0, pa - 16'h0300}, 1'b0);
    cmd(ddcm_pkg::CP_FREQ_A_HI, 16'h0000, 1'b0);
    apb(1'b1, ddcm_pkg::REG_SYNC, 32'h14, 32'h0, 1'b0);
    rd(ddcm_pkg::REG_PHASE, {16'h0, pa}, 1'b0);
    // three refused mode words, then a legal remix word
    for (int k = 0; k < 4; k++) begin
      cmd(ddcm_pkg::CP_MODE, bad[k], k != 3);
    end
    rd(ddcm_pkg::REG_STATUS, 32'h0001000b, 1'b0);
    apb(1'b1, ddcm_pkg::REG_STATUS, 32'h00010000, 32'h0, 1'b0);
    rd(ddcm_pkg::REG_STATUS, 32'h0000000b, 1'b0);
    rd(ddcm_pkg::REG_CMD, 32'h0006000b, 1'b0);
    // second stream with its own route and phase
    cmd(ddcm_pkg::CP_PHASE_B, 16'h2000, 1'b0);
    cmd(ddcm_pkg::CP_MODE, 16'h000d, 1'b0);
    zq = 1'b1;
    boost = 1'b1;
    apb(1'b1, ddcm_pkg::REG_SYNC, 32'h12, 32'h0, 1'b0);
    pb = 16'h2000;
    stream(1'b1);
    // every input rate: strobe count, no second stream, one result
    zq = 1'b0;
    for (int r = 0; r < 4; r++) begin
      apb(1'b1, ddcm_pkg::REG_RATE, 32'(r), 32'h0, 1'b0);
      cmd(ddcm_pkg::CP_MODE, {7'h00, 2'(r), 7'h08}, 1'b0);
      rd(ddcm_pkg::REG_RATE, 32'(r), 1'b0);
      na = 0;
      nb = 0;
      repeat (64) begin
        @(posedge clk);
        na += (out_valid[0] === 1'b1);
        nb += (out_valid[1] === 1'b1);
      end
      chk_cnt(na, 64 >> r);
      chk_cnt(nb, 0);
      stream(1'b0);
    end
    complete_run();
  end
endmodule
`default_nettype wire
